// ===== bst_tap.sv
// Boundary-scan test access port: controller, instruction register,
// bypass, identification and boundary-scan data registers.
// Assumes a tester drives the test pins asynchronously to core_clk,
// with a test clock well below a quarter of the core clock rate.
`timescale 1ns/1ps
`include "bst_map.svh"

// Behaviour
// - Controller steps on test clock rising edges
// - Power-up: reset state, identification instruction loaded
// - Run-Test-Idle holds instruction and data registers
// - Select-DR: hold; low capture, high Select-IR
// - Capture-DR loads selected register if allowed
// - Shift-DR shifts selected register toward output
// - Exit1-DR: high Update-DR, low Pause-DR
// - Pause-DR holds, stays low, high to Exit2-DR
// - Exit2-DR: high Update-DR, low Shift-DR
// - Update-DR falling edge loads output latches
// - Select-IR: hold; low Capture-IR, high reset
// - Capture-IR loads fixed value; next by mode
// - Shift-IR shifts instruction; high to Exit1-IR
// - Exit1-IR: low Pause-IR, high Update-IR
// - Pause-IR halts, stays low, high Exit2-IR
// - Exit2-IR with mode high goes Update-IR
// - Update-IR falling edge makes new current instruction
// - Update-IR: low Run-Test-Idle, high Select-DR
// - Instruction register: 3-bit shift plus latch
// - Codes 010, 000 boundary; 111 bypass
// - Codes 011, 100 bypass; 001 identification
// - Identification: 32 bits, LSB one, three fields
// - Identification code captured in Capture-DR
// - Bypass is one stage, serial short path
// - High-impedance and clamp instruction output control
module bst_tap #(
  parameter int          BSR_LEN    = `BST_BSR_LEN,
  parameter logic [3:0]  ID_VERSION = 4'h1,       // Arbitrary value
  parameter logic [15:0] ID_DEVICE  = 16'h5a3c,   // Arbitrary value
  parameter logic [10:0] ID_MANUF   = 11'h2b6     // Arbitrary value
) (
  input  wire logic               core_clk,             // Core clock, 40 MHz
  input  wire logic               rst,                  // Synchronous reset, high
  input  wire logic               test_port_reset_n,    // Test reset pin, low
  input  wire logic               test_port_clock,      // Test clock pin
  input  wire logic               test_mode_select_in,  // Mode select pin
  input  wire logic               test_serial_in,       // Serial data in pin
  output logic                    test_serial_out,      // Serial data out
  output logic                    test_serial_out_en_n, // Output enable, low drives
  input  wire logic [BSR_LEN-1:0] bsr_capture_in,       // Sampled system pins
  output logic [BSR_LEN-1:0]      bsr_update_out,       // Boundary output latches
  output logic                    sys_out_from_bsr,     // Pins driven from latches
  output logic                    sys_out_highz,        // All outputs released
  output logic [`BST_IR_W-1:0]    current_instruction   // Latched instruction
);

  if (BSR_LEN < 1) begin : g_chk
    $error("BSR_LEN must be at least 1");
  end

  localparam logic [`BST_ID_W-1:0] ID_CODE = {ID_VERSION, ID_DEVICE, ID_MANUF, 1'b1};

  // ----------------------------------------------------------------
  // Pin synchroniser and test clock edges
  // ----------------------------------------------------------------
  bst_pkg::bst_pins_s pin_m;
  bst_pkg::bst_pins_s pin_s;
  logic               tck_d;
  logic               tck_rise;
  logic               tck_fall;
  logic               tms;
  logic               tdi;

  // Reset values are constants; pins only reach the first stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_m <= '{rst_n: 1'b1, tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      pin_s <= '{rst_n: 1'b1, tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      tck_d <= 1'b0;
    end else begin
      pin_m <= '{rst_n: test_port_reset_n, tck: test_port_clock,
                 tms: test_mode_select_in, tdi: test_serial_in};
      pin_s <= pin_m;
      tck_d <= pin_s.tck;
    end
  end

  assign tck_rise = pin_s.tck & ~tck_d;
  assign tck_fall = ~pin_s.tck & tck_d;
  assign tms      = pin_s.tms;
  assign tdi      = pin_s.tdi;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  bst_pkg::bst_state_e state;
  bst_pkg::bst_state_e next_state;

  always_comb begin
    next_state = state;
    if (!pin_s.rst_n) begin
      next_state = bst_pkg::st_tlr;
    end else if (tck_rise) begin
      case (state)
        bst_pkg::st_tlr:      next_state = tms ? bst_pkg::st_tlr : bst_pkg::st_rti;
        bst_pkg::st_rti:      next_state = tms ? bst_pkg::st_sel_dr : bst_pkg::st_rti;
        bst_pkg::st_sel_dr:   next_state = tms ? bst_pkg::st_sel_ir : bst_pkg::st_cap_dr;
        bst_pkg::st_cap_dr:   next_state = tms ? bst_pkg::st_exit1_dr : bst_pkg::st_shift_dr;
        bst_pkg::st_shift_dr: next_state = tms ? bst_pkg::st_exit1_dr : bst_pkg::st_shift_dr;
        bst_pkg::st_exit1_dr: next_state = tms ? bst_pkg::st_upd_dr : bst_pkg::st_pause_dr;
        bst_pkg::st_pause_dr: next_state = tms ? bst_pkg::st_exit2_dr : bst_pkg::st_pause_dr;
        bst_pkg::st_exit2_dr: next_state = tms ? bst_pkg::st_upd_dr : bst_pkg::st_shift_dr;
        bst_pkg::st_upd_dr:   next_state = tms ? bst_pkg::st_sel_dr : bst_pkg::st_rti;
        bst_pkg::st_sel_ir:   next_state = tms ? bst_pkg::st_tlr : bst_pkg::st_cap_ir;
        bst_pkg::st_cap_ir:   next_state = tms ? bst_pkg::st_exit1_ir : bst_pkg::st_shift_ir;
        bst_pkg::st_shift_ir: next_state = tms ? bst_pkg::st_exit1_ir : bst_pkg::st_shift_ir;
        bst_pkg::st_exit1_ir: next_state = tms ? bst_pkg::st_upd_ir : bst_pkg::st_pause_ir;
        bst_pkg::st_pause_ir: next_state = tms ? bst_pkg::st_exit2_ir : bst_pkg::st_pause_ir;
        bst_pkg::st_exit2_ir: next_state = tms ? bst_pkg::st_upd_ir : bst_pkg::st_shift_ir;
        bst_pkg::st_upd_ir:   next_state = tms ? bst_pkg::st_sel_dr : bst_pkg::st_rti;
        default:              next_state = bst_pkg::st_tlr;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= bst_pkg::st_tlr;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Instruction and data registers, serial output
  // ----------------------------------------------------------------
  logic [`BST_IR_W-1:0] ir_shift;
  logic [`BST_IR_W-1:0] next_ir_shift;
  logic [`BST_IR_W-1:0] next_instruction;
  logic                 byp;
  logic                 next_byp;
  logic [`BST_ID_W-1:0] id_shift;
  logic [`BST_ID_W-1:0] next_id_shift;
  logic [BSR_LEN-1:0]   bsr_shift;
  logic [BSR_LEN-1:0]   next_bsr_shift;
  logic [BSR_LEN-1:0]   next_bsr_update;
  logic                 next_tdo;
  logic                 next_tdo_en_n;
  logic                 next_from_bsr;
  logic                 next_highz;
  bst_pkg::bst_dr_sel_e dr_sel;

  function automatic bst_pkg::bst_dr_sel_e decode_sel(input logic [`BST_IR_W-1:0] code);
    case (code)
      `BST_IR_EXTEST, `BST_IR_SAMPLE: decode_sel = bst_pkg::sel_bsr;
      `BST_IR_IDCODE:                 decode_sel = bst_pkg::sel_id;
      default:                        decode_sel = bst_pkg::sel_byp;
    endcase
  endfunction : decode_sel

  assign dr_sel = decode_sel(current_instruction);

  // Scan registers change only on test clock edges, so Run-Test-Idle,
  // select and pause states hold everything by construction
  always_comb begin
    next_ir_shift    = ir_shift;
    next_instruction = current_instruction;
    next_byp         = byp;
    next_id_shift    = id_shift;
    next_bsr_shift   = bsr_shift;
    next_bsr_update  = bsr_update_out;
    next_tdo         = test_serial_out;
    next_tdo_en_n    = test_serial_out_en_n;
    if (tck_rise) begin
      case (state)
        bst_pkg::st_cap_ir:   next_ir_shift = `BST_IR_CAPTURE;
        bst_pkg::st_shift_ir: next_ir_shift = {tdi, ir_shift[`BST_IR_W-1:1]};
        bst_pkg::st_cap_dr: begin
          case (dr_sel)
            bst_pkg::sel_bsr: next_bsr_shift = bsr_capture_in;
            bst_pkg::sel_id:  next_id_shift  = ID_CODE;
            default:          next_byp       = 1'b0;
          endcase
        end
        bst_pkg::st_shift_dr: begin
          case (dr_sel)
            bst_pkg::sel_bsr: next_bsr_shift = {tdi, bsr_shift[BSR_LEN-1:1]};
            bst_pkg::sel_id:  next_id_shift  = {tdi, id_shift[`BST_ID_W-1:1]};
            default:          next_byp       = tdi;
          endcase
        end
        default: ;
      endcase
    end
    if (tck_fall) begin
      if (state == bst_pkg::st_upd_ir) begin
        next_instruction = ir_shift;
      end
      if (state == bst_pkg::st_upd_dr && dr_sel == bst_pkg::sel_bsr) begin
        next_bsr_update = bsr_shift;
      end
      next_tdo_en_n = 1'b1;
      if (state == bst_pkg::st_shift_ir) begin
        next_tdo      = ir_shift[0];
        next_tdo_en_n = 1'b0;
      end else if (state == bst_pkg::st_shift_dr) begin
        next_tdo_en_n = 1'b0;
        case (dr_sel)
          bst_pkg::sel_bsr: next_tdo = bsr_shift[0];
          bst_pkg::sel_id:  next_tdo = id_shift[0];
          default:          next_tdo = byp;
        endcase
      end
    end
    if (state == bst_pkg::st_tlr) begin
      next_instruction = `BST_IR_IDCODE;
    end
    // Clamp keeps the latched values on the pins; high-impedance releases
    next_from_bsr = (next_instruction == `BST_IR_EXTEST) ||
                    (next_instruction == `BST_IR_CLAMP);
    next_highz    = (next_instruction == `BST_IR_HIGHZ);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ir_shift             <= `BST_IR_CAPTURE;
      current_instruction  <= `BST_IR_IDCODE;
      byp                  <= 1'b0;
      id_shift             <= '0;
      bsr_shift            <= '0;
      bsr_update_out       <= '0;
      test_serial_out      <= 1'b0;
      test_serial_out_en_n <= 1'b1;
      sys_out_from_bsr     <= 1'b0;
      sys_out_highz        <= 1'b0;
    end else begin
      ir_shift             <= next_ir_shift;
      current_instruction  <= next_instruction;
      byp                  <= next_byp;
      id_shift             <= next_id_shift;
      bsr_shift            <= next_bsr_shift;
      bsr_update_out       <= next_bsr_update;
      test_serial_out      <= next_tdo;
      test_serial_out_en_n <= next_tdo_en_n;
      sys_out_from_bsr     <= next_from_bsr;
      sys_out_highz        <= next_highz;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_rise_low;
    pin_s.rst_n && tck_rise && !tms;
  endsequence
  sequence s_rise_high;
    pin_s.rst_n && tck_rise && tms;
  endsequence

  property p_tlr_loop;
    (state == bst_pkg::st_tlr) ##0 s_rise_high |=> state == bst_pkg::st_tlr;
  endproperty
  a_tlr_loop: assert property (p_tlr_loop) else $error("reset state left on high");

  property p_sel_dr;
    (state == bst_pkg::st_sel_dr) ##0 s_rise_low |=> state == bst_pkg::st_cap_dr;
  endproperty
  a_sel_dr: assert property (p_sel_dr) else $error("select-DR did not capture");

  property p_pause_dr;
    (state == bst_pkg::st_pause_dr) ##0 s_rise_low |=>
      state == bst_pkg::st_pause_dr && $stable(bsr_shift) && $stable(id_shift);
  endproperty
  a_pause_dr: assert property (p_pause_dr) else $error("pause-DR did not hold");

  property p_exit2_ir;
    (state == bst_pkg::st_exit2_ir) ##0 s_rise_low |=> state == bst_pkg::st_shift_ir;
  endproperty
  a_exit2_ir: assert property (p_exit2_ir) else $error("exit2-IR low not shift");

  property p_cap_ir;
    (state == bst_pkg::st_cap_ir && tck_rise) |=> ir_shift == `BST_IR_CAPTURE;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-IR value wrong");

  property p_upd_ir;
    (state == bst_pkg::st_upd_ir && tck_fall) |=> current_instruction == $past(ir_shift);
  endproperty
  a_upd_ir: assert property (p_upd_ir) else $error("instruction not latched");

  property p_tlr_id;
    state == bst_pkg::st_tlr |=> current_instruction == `BST_IR_IDCODE;
  endproperty
  a_tlr_id: assert property (p_tlr_id) else $error("reset state lost idcode");

  property p_idle_hold;
    state == bst_pkg::st_rti |=> $stable(current_instruction) && $stable(bsr_update_out);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle changed registers");

  property p_pin_reset;
    !pin_s.rst_n |=> state == bst_pkg::st_tlr;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");

  property p_bypass;
    (state == bst_pkg::st_shift_dr && tck_rise && dr_sel == bst_pkg::sel_byp) |=>
      byp == $past(tdi);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass stage wrong");

  property p_oe_off;
    (tck_fall && state != bst_pkg::st_shift_dr && state != bst_pkg::st_shift_ir) |=>
      test_serial_out_en_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("serial out driven outside shift");

endmodule : bst_tap

// ===== bst_map.svh
// Constants of the boundary-scan test access port: instruction codes,
// register widths and the capture pattern. Definitions only.
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

`define BST_IR_W       3
`define BST_IR_EXTEST  3'h0
`define BST_IR_IDCODE  3'h1
`define BST_IR_SAMPLE  3'h2
`define BST_IR_CLAMP   3'h3
`define BST_IR_HIGHZ   3'h4
`define BST_IR_BYPASS  3'h7
`define BST_IR_CAPTURE 3'h1
`define BST_ID_W       32
`define BST_BSR_LEN    99

`endif

// ===== bst_pkg.sv
// Types shared by the boundary-scan test access port.
// Assumes the constants of bst_map.svh for widths.
package bst_pkg;

  // ----------------------------------------------------------------
  // Controller states and data register selection
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_tlr, st_rti, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr,
    st_pause_dr, st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir,
    st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } bst_state_e;

  typedef enum logic [1:0] {
    sel_bsr, sel_byp, sel_id
  } bst_dr_sel_e;

  // Test port pins as seen after the synchroniser
  typedef struct packed {
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_s;

endpackage : bst_pkg

// ===== bst_tester.sv
// Behavioural test controller that drives the test port pins bit by bit.
// Assumes a free-running core clock; pins change on its falling edge only.
`timescale 1ns/1ps
module bst_tester (
  input  wire logic core_clk,  // Core clock, timing reference only
  output logic      tck,       // Test clock, still between steps
  output logic      tms,       // Mode select
  output logic      tdi,       // Serial data to the port
  output logic      rst_n,     // Test reset, low
  input  wire logic tdo,       // Serial data from the port
  input  wire logic tdo_en_n   // Port drives tdo while low
);
  initial begin
    tck   = 1'b0;
    tms   = 1'b1;
    tdi   = 1'b1;
    rst_n = 1'b1;
  end

  // One 200 ns test clock, four core cycles low and four high; mode and data
  // settle three core cycles before the rise so the synchroniser sees them
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge core_clk);
    tms = m;
    tdi = d;
    repeat (3) @(negedge core_clk);
    o = tdo_en_n ? 1'bz : tdo;
    tck = 1'b1;
    repeat (4) @(negedge core_clk);
    tck = 1'b0;
  endtask : step

  // Reset pin held low long enough to pass the synchroniser
  task automatic pin_reset();
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
  endtask : pin_reset
endmodule : bst_tester

// ===== tb_top.sv
// Self-checking bench for the test access port, driven by a tester model.
// Assumes a short boundary register so a full scan stays brief.
`timescale 1ns/1ps
module tb_top;
  localparam int          BL = 8;
  localparam logic [31:0] ID = {4'h9, 16'h1234, 11'h0f3, 1'b1}; // Arbitrary value
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic [BL-1:0] bsr_cap = '0;
  logic          tck, tms, tdi, trst_n, tdo, tdo_en_n, from_bsr, highz;
  logic [BL-1:0] bsr_upd;
  logic [2:0]    cur_ir;
  int            err_count = 0;
  int            num_checks = 0;

  always #12.5 core_clk = ~core_clk;

  bst_tester i_bst_tester (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .rst_n(trst_n), .tdo(tdo), .tdo_en_n(tdo_en_n));

  bst_tap #(.BSR_LEN(BL), .ID_VERSION(ID[31:28]), .ID_DEVICE(ID[27:12]),
    .ID_MANUF(ID[11:1])) i_bst_tap (.core_clk(core_clk), .rst(rst),
    .test_port_reset_n(trst_n), .test_port_clock(tck), .test_mode_select_in(tms),
    .test_serial_in(tdi), .test_serial_out(tdo), .test_serial_out_en_n(tdo_en_n),
    .bsr_capture_in(bsr_cap), .bsr_update_out(bsr_upd), .sys_out_from_bsr(from_bsr),
    .sys_out_highz(highz), .current_instruction(cur_ir));

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Mode select sequence, first bit in bit 0; returns the last sampled output
  task automatic seq(input logic [7:0] s, input int n, output logic o);
    for (int i = 0; i < n; i++) i_bst_tester.step(s[i], 1'b0, o);
  endtask : seq

  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask : settle

  // Shift n bits from a shift state, leaving through Exit1 on the last
  task automatic scan(input logic [127:0] din, input int n, output logic [127:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      i_bst_tester.step(i == n - 1, din[i], o);
      dout[i] = o;
    end
  endtask : scan

  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic         o;
    logic [127:0] d;
    seq(8'b0011, 4, o);
    scan(code, 3, d);
    cap = d[2:0];
    seq(8'b01, 2, o);
    settle();
  endtask : load_ir

  task automatic t_idcode();
    logic         o;
    logic [127:0] d;
    chk("instruction after reset", 3'h1, cur_ir);
    seq(8'b0, 1, o);
    seq(8'b001, 3, o);
    scan('0, 32, d);
    chk("identification", ID, d[31:0]);
    seq(8'b01, 2, o);
    settle();
    $display("test idcode done");
  endtask : t_idcode

  task automatic t_codes();
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [2:0] cap;
    foreach (codes[k]) begin
      load_ir(codes[k], cap);
      chk("ir capture", 3'h1, cap);
      chk("instruction", codes[k], cur_ir);
      chk("from_bsr", codes[k] == 3'h0 || codes[k] == 3'h3, from_bsr);
      chk("highz", codes[k] == 3'h4, highz);
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_bypass();
    logic         o;
    logic [2:0]   cap;
    logic [127:0] d;
    load_ir(3'h7, cap);
    seq(8'b001, 3, o);
    scan(4'b1011, 4, d);
    chk("bypass out", 4'b0110, d[3:0]);
    seq(8'b00, 2, o);
    chk("out in pause", 1'bz, o);
    seq(8'b01, 2, o);
    scan(2'b00, 2, d);
    chk("bypass resume", 2'b01, d[1:0]);
    seq(8'b01, 2, o);
    settle();
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_bsr();
    logic         o;
    logic [2:0]   cap;
    logic [127:0] d;
    load_ir(3'h2, cap);
    bsr_cap = 8'ha5;
    seq(8'b001, 3, o);
    scan(8'h3c, BL, d);
    settle();
    chk("bsr capture", 8'ha5, d[BL-1:0]);
    chk("latch held", 8'h00, bsr_upd);
    seq(8'b01, 2, o);
    settle();
    chk("latch updated", 8'h3c, bsr_upd);
    load_ir(3'h0, cap);
    chk("latch under extest", 8'h3c, bsr_upd);
    $display("test bsr done");
  endtask : t_bsr

  task automatic t_resets();
    logic       o;
    logic [2:0] cap;
    load_ir(3'h7, cap);
    i_bst_tester.pin_reset();
    settle();
    chk("instruction after pin reset", 3'h1, cur_ir);
    seq(8'b0, 1, o);
    load_ir(3'h7, cap);
    seq(8'b111, 3, o);
    settle();
    chk("instruction after mode reset", 3'h1, cur_ir);
    seq(8'b01, 2, o);
    seq(8'b0011, 4, o);
    i_bst_tester.step(1'b0, 1'b0, o);
    i_bst_tester.step(1'b1, 1'b0, o);
    seq(8'b0010, 4, o);
    i_bst_tester.step(1'b1, 1'b1, o);
    seq(8'b01, 2, o);
    settle();
    chk("instruction via pause", 3'h4, cur_ir);
    chk("highz via pause", 1'b1, highz);
    $display("test resets done");
  endtask : t_resets

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #400000;
    err_count++;
    $display("unexpected timeout: expected done seen running");
    end_of_test();
  end

  initial begin
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    t_idcode();
    t_codes();
    t_bypass();
    t_bsr();
    t_resets();
    end_of_test();
  end
endmodule : tb_top
